// ===== logic/admc_mode_ctrl.sv
// admc_mode_ctrl: operating mode controller of the analog companion die.
// assumes async analog comparator levels and wake detects on the inputs, and
// register accesses from the die-to-die interface on the same clock.
`timescale 1ns/1ps
`include "admc_params.svh"

module admc_mode_ctrl #(
    parameter int unsigned RST_CYCLES = `ADMC_RST_CYCLES,
    parameter int unsigned VTO_CYCLES = `ADMC_VTO_CYCLES
) (
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire admc_pkg::admc_d2d_req_t d2d_req,
    input  wire logic                   wake_src_read,
    input  wire logic [5:0]             cause_clear,
    input  wire logic                   d2d_wake_cmd,
    input  wire logic                   watchdog_expired,
    input  wire logic                   watchdog_service,
    input  wire logic                   main_supply_ok,
    input  wire logic                   core_supply_ok,
    input  wire logic                   io_supply_ok,
    input  wire logic                   main_above_lvi,
    input  wire logic                   reset_pin_in,
    input  wire logic                   wake_inputs_event,
    input  wire logic                   lin_wake_event,
    input  wire logic                   forced_wake_event,
    output logic [7:0]                  d2d_rdata,
    output logic                        reset_pin_out,
    output logic                        reset_pin_oe,
    output logic                        regulators_on,
    output logic                        regulators_full_current,
    output admc_pkg::admc_gate_t        func_gate,
    output logic                        wake_irq,
    output logic                        watchdog_windowed,
    output admc_pkg::admc_mode_t        op_mode,
    output logic [5:0]                  reset_cause_register
);

    // refuse counts the state fields cannot hold
    if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_rst_chk
        $error("RST_CYCLES out of range");
    end
    if (VTO_CYCLES < 1 || VTO_CYCLES > 16777215) begin : g_vto_chk
        $error("VTO_CYCLES out of range");
    end

    // register hit at either base of the global address space
    function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] ofs);
        reg_hit = (addr == 16'(`ADMC_BASE_BLOCKING + ofs)) || (addr == 16'(`ADMC_BASE_NONBLOCK + ofs));
    endfunction : reg_hit

    admc_pkg::admc_state_t s_r;
    admc_pkg::admc_state_t s_nxt;

    logic por_ok;
    logic core_ok;
    logic io_ok;
    logic lvi_ok;
    logic pin_hi;
    logic wake_sleep;
    logic wake_stop;
    logic int_cause;
    logic vto_hit;
    logic wr_mode;
    logic [5:0] cause_set;

    // next state of the whole controller
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = {forced_wake_event, lin_wake_event, wake_inputs_event, reset_pin_in,
                       main_above_lvi, io_supply_ok, core_supply_ok, main_supply_ok};
        s_nxt.sync2 = s_r.sync1;
        por_ok  = s_r.sync2[`ADMC_SY_POR];
        core_ok = s_r.sync2[`ADMC_SY_CORE];
        io_ok   = s_r.sync2[`ADMC_SY_IO];
        lvi_ok  = s_r.sync2[`ADMC_SY_LVI];
        pin_hi  = s_r.sync2[`ADMC_SY_PIN];
        // interface command has no effect in sleep
        wake_sleep = s_r.sync2[`ADMC_SY_WKIN] | s_r.sync2[`ADMC_SY_LIN] | s_r.sync2[`ADMC_SY_FWU];
        wr_mode = d2d_req.wr && reg_hit(d2d_req.addr, `ADMC_OFS_MODE)
                  && (s_r.st == admc_pkg::ST_NORMAL || s_r.st == admc_pkg::ST_STOP);
        wake_stop = wake_sleep | d2d_wake_cmd
                    | (wr_mode && d2d_req.wdata[1:0] == `ADMC_MODE_WAKE);

        // reset causes
        cause_set = 6'h00;
        cause_set[`ADMC_C_POR] = (s_r.st == admc_pkg::ST_PDOWN) && por_ok;
        if (s_r.st == admc_pkg::ST_NORMAL || s_r.st == admc_pkg::ST_STOP) begin
            cause_set[`ADMC_C_LVR]  = !core_ok;
            cause_set[`ADMC_C_IO_UNDERVOLTAGE_CAUSE] = !io_ok;
        end
        cause_set[`ADMC_C_WDR] = watchdog_expired && s_r.st == admc_pkg::ST_NORMAL;
        // pin pulled low from outside, not by our own recent drive
        cause_set[`ADMC_C_EXR] = !pin_hi && !s_r.pin_oe && s_r.drv_hist == 2'h0
                                 && s_r.st != admc_pkg::ST_PDOWN && s_r.st != admc_pkg::ST_SLEEP;
        cause_set[`ADMC_C_WUR] = (s_r.st == admc_pkg::ST_SLEEP) && wake_sleep && por_ok;
        int_cause = (s_r.st == admc_pkg::ST_PDOWN) || cause_set[`ADMC_C_LVR] || cause_set[`ADMC_C_IO_UNDERVOLTAGE_CAUSE]
                    || cause_set[`ADMC_C_WDR] || cause_set[`ADMC_C_WUR]
                    || (s_r.st == admc_pkg::ST_RESET && (!core_ok || !io_ok));

        // sticky flags, a new cause wins over a clear
        s_nxt.cause = (s_r.cause & ~cause_clear) | cause_set;

        // reset pin hold after an internal cause ends
        if (int_cause) begin
            s_nxt.hold_cnt = 16'(RST_CYCLES);
        end else if (s_r.hold_cnt != 16'h0000) begin
            s_nxt.hold_cnt = s_r.hold_cnt - 16'h0001;
        end
        s_nxt.pin_oe   = int_cause || s_nxt.hold_cnt != 16'h0000;
        s_nxt.drv_hist = {s_r.drv_hist[0], s_r.pin_oe};

        // short-circuit timeout on either regulator output
        vto_hit = 1'b0;
        if ((!core_ok || !io_ok) && lvi_ok && (s_r.st == admc_pkg::ST_RESET
            || s_r.st == admc_pkg::ST_NORMAL || s_r.st == admc_pkg::ST_STOP)) begin
            s_nxt.vto_cnt = s_r.vto_cnt + 24'h00_0001;
            vto_hit = s_r.vto_cnt >= 24'(VTO_CYCLES);
        end else begin
            s_nxt.vto_cnt = 24'h00_0000;
        end

        // wake source read re-arms stop after the required gap
        if (s_r.gap_cnt != 2'h0) begin
            s_nxt.gap_cnt = s_r.gap_cnt - 2'h1;
        end
        if (wake_src_read) begin
            s_nxt.stop_block = 1'b0;
            s_nxt.gap_cnt    = `ADMC_WSR_GAP;
            s_nxt.wake_irq   = 1'b0;
        end
        if (wr_mode) begin
            s_nxt.mode = d2d_req.wdata[1:0];
        end
        if (watchdog_service && s_r.st == admc_pkg::ST_NORMAL) begin
            s_nxt.wd_windowed = 1'b1;
        end

        // mode sequencing
        case (s_r.st)
            admc_pkg::ST_PDOWN: begin
                if (por_ok) begin
                    s_nxt.st = admc_pkg::ST_RESET;
                end
            end
            admc_pkg::ST_RESET: begin
                s_nxt.mode = `ADMC_MODE_RST_VAL;
                if (vto_hit) begin
                    s_nxt.st = admc_pkg::ST_SLEEP;
                end else if (pin_hi && core_ok && io_ok && !s_r.pin_oe) begin
                    s_nxt.st          = admc_pkg::ST_NORMAL;
                    s_nxt.wd_windowed = 1'b0;
                end
            end
            admc_pkg::ST_NORMAL: begin
                if (vto_hit) begin
                    s_nxt.st = admc_pkg::ST_SLEEP;
                end else if (cause_set != 6'h00) begin
                    s_nxt.st = admc_pkg::ST_RESET;
                end else if (wr_mode && d2d_req.wdata[1:0] == `ADMC_MODE_STOP
                             && !s_r.stop_block && s_r.gap_cnt == 2'h0) begin
                    s_nxt.st = admc_pkg::ST_STOP;
                end else if (wr_mode && d2d_req.wdata[1:0] == `ADMC_MODE_SLEEP) begin
                    s_nxt.st = admc_pkg::ST_SLEEP;
                end
                // a 00 or 11 write here starts nothing
            end
            admc_pkg::ST_STOP: begin
                if (vto_hit) begin
                    s_nxt.st = admc_pkg::ST_SLEEP;
                end else if (cause_set != 6'h00) begin
                    s_nxt.st = admc_pkg::ST_RESET;
                end else if (wr_mode && d2d_req.wdata[1:0] == `ADMC_MODE_SLEEP) begin
                    s_nxt.st = admc_pkg::ST_SLEEP;
                end else if (wake_stop) begin
                    s_nxt.st         = admc_pkg::ST_NORMAL;
                    s_nxt.wake_irq   = 1'b1;
                    s_nxt.stop_block = 1'b1;
                end
            end
            admc_pkg::ST_SLEEP: begin
                if (cause_set[`ADMC_C_WUR]) begin
                    s_nxt.st = admc_pkg::ST_RESET;
                end
            end
            default: begin
                s_nxt.st = admc_pkg::ST_PDOWN;
            end
        endcase
        if (!por_ok) begin
            s_nxt.st = admc_pkg::ST_PDOWN;
        end

        // regulator control and function gating from the coming mode
        s_nxt.reg_on   = s_nxt.st != admc_pkg::ST_SLEEP && s_nxt.st != admc_pkg::ST_PDOWN;
        s_nxt.reg_full = s_nxt.st == admc_pkg::ST_RESET || s_nxt.st == admc_pkg::ST_NORMAL;
        s_nxt.gate = '0;
        if (s_nxt.st == admc_pkg::ST_NORMAL) begin
            s_nxt.gate = '1;
            s_nxt.gate.high_side_cyclic   = 1'b0;
            s_nxt.gate.wake_inputs_detect = 1'b0;
            s_nxt.gate.lin_wake_detect    = 1'b0;
            s_nxt.gate.cyclic_sense       = 1'b0;
        end else if (s_nxt.st == admc_pkg::ST_STOP || s_nxt.st == admc_pkg::ST_SLEEP) begin
            s_nxt.gate.high_side_cyclic   = 1'b1;
            s_nxt.gate.wake_inputs_detect = 1'b1;
            s_nxt.gate.lin_wake_detect    = 1'b1;
            s_nxt.gate.cyclic_sense       = 1'b1;
            s_nxt.gate.d2d                = s_nxt.st == admc_pkg::ST_STOP;
        end

        // register read answer, one cycle after the request
        s_nxt.rdata = 8'h00;
        if (d2d_req.rd && reg_hit(d2d_req.addr, `ADMC_OFS_MODE)) begin
            s_nxt.rdata = {6'h00, s_r.mode};
        end
    end

    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.st <= admc_pkg::ST_PDOWN;
            s_r.mode <= `ADMC_MODE_RST_VAL;
            s_r.pin_oe <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register, reset pin data tied low
    assign d2d_rdata               = s_r.rdata;
    assign reset_pin_out           = 1'b0;
    assign reset_pin_oe            = s_r.pin_oe;
    assign regulators_on           = s_r.reg_on;
    assign regulators_full_current = s_r.reg_full;
    assign func_gate               = s_r.gate;
    assign wake_irq                = s_r.wake_irq;
    assign watchdog_windowed       = s_r.wd_windowed;
    assign op_mode                 = s_r.st;
    assign reset_cause_register    = s_r.cause;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence stop_wake_seq;
        s_r.st == admc_pkg::ST_STOP ##1 s_r.st == admc_pkg::ST_NORMAL;
    endsequence
    sequence reset_exit_seq;
        s_r.st == admc_pkg::ST_RESET ##1 s_r.st == admc_pkg::ST_NORMAL;
    endsequence

    a_sleep_regs_off: assert property (s_r.st == admc_pkg::ST_SLEEP |-> !s_r.reg_on && !s_r.reg_full)
        else $error("regulators on in sleep");
    a_stop_wake_irq: assert property (stop_wake_seq |-> s_r.wake_irq && s_r.stop_block)
        else $error("stop wake without interrupt");
    a_sleep_wake_rst: assert property (s_r.st == admc_pkg::ST_SLEEP && wake_sleep && por_ok
        |=> s_r.st == admc_pkg::ST_RESET && s_r.reg_on && s_r.cause[`ADMC_C_WUR])
        else $error("sleep wake not into reset");
    a_por_record: assert property (s_r.st == admc_pkg::ST_PDOWN ##1 s_r.st == admc_pkg::ST_RESET
        |-> s_r.cause[`ADMC_C_POR])
        else $error("power-on cause not recorded");
    a_pin_hold: assert property ($fell(s_r.pin_oe) |-> $past(s_r.hold_cnt) == 16'h0001)
        else $error("reset pin released early");
    a_normal_entry: assert property (reset_exit_seq |-> $past(pin_hi && core_ok && io_ok, 1))
        else $error("normal entered without release conditions");
    a_vto_sleep: assert property (vto_hit && por_ok |=> s_r.st == admc_pkg::ST_SLEEP)
        else $error("undervoltage timeout missed");
    a_cause_sticky: assert property (s_r.cause[`ADMC_C_WDR] && !cause_clear[`ADMC_C_WDR]
        |=> s_r.cause[`ADMC_C_WDR])
        else $error("cause flag lost");
    a_wd_initial: assert property (reset_exit_seq |-> !s_r.wd_windowed)
        else $error("watchdog windowed at normal entry");
    a_stop_limited: assert property (s_r.st == admc_pkg::ST_STOP |-> s_r.reg_on && !s_r.reg_full
        && s_r.gate.d2d && !s_r.gate.adc)
        else $error("stop supply or gating wrong");
    a_stop_refused: assert property (s_r.st == admc_pkg::ST_NORMAL && s_r.stop_block
        |=> s_r.st != admc_pkg::ST_STOP)
        else $error("stop taken before wake source read");
    a_wake_write_nop: assert property (s_r.st == admc_pkg::ST_NORMAL && wr_mode && !vto_hit
        && d2d_req.wdata[1:0] == `ADMC_MODE_WAKE && cause_set == 6'h00 && por_ok
        |=> s_r.st == admc_pkg::ST_NORMAL)
        else $error("00 write changed normal mode");

    // per-mode regulator drive and function gating
    a_sleep_gating: assert property (s_r.st == admc_pkg::ST_SLEEP |-> !s_r.gate.d2d && !s_r.gate.adc
        && !s_r.gate.watchdog && s_r.gate.lin_wake_detect && !s_r.gate.lin_full)
        else $error("sleep gating wrong");
    a_stop_gating: assert property (s_r.st == admc_pkg::ST_STOP |-> !s_r.gate.sensor_supply
        && !s_r.gate.low_side_drivers && s_r.gate.wake_inputs_detect && !s_r.gate.wake_inputs_full)
        else $error("stop gating wrong");
    a_normal_full: assert property (s_r.st == admc_pkg::ST_NORMAL |-> s_r.reg_on && s_r.reg_full
        && s_r.gate.adc && s_r.gate.watchdog && !s_r.gate.cyclic_sense)
        else $error("normal not at full function");

    // transitions, reset pin drive and interrupt clear that must or must not follow
    a_pdown_hold: assert property (!por_ok |=> s_r.st == admc_pkg::ST_PDOWN && !s_r.reg_on)
        else $error("left power down without supply");
    a_stop_reset: assert property (s_r.st == admc_pkg::ST_STOP && cause_set != 6'h00 && !vto_hit && por_ok
        |=> s_r.st == admc_pkg::ST_RESET)
        else $error("reset cause in stop missed");
    a_sleep_cmd_nop: assert property (s_r.st == admc_pkg::ST_SLEEP && d2d_wake_cmd && !wake_sleep && por_ok
        |=> s_r.st == admc_pkg::ST_SLEEP)
        else $error("interface command woke sleep");
    a_stop_gap: assert property (s_r.st == admc_pkg::ST_NORMAL && s_r.gap_cnt != 2'h0
        |=> s_r.st != admc_pkg::ST_STOP)
        else $error("stop taken inside read gap");
    a_pin_drive: assert property (cause_set[`ADMC_C_WDR] || cause_set[`ADMC_C_WUR] |=> s_r.pin_oe)
        else $error("reset pin not driven");
    a_irq_clear: assert property (wake_src_read && s_r.st == admc_pkg::ST_NORMAL |=> !s_r.wake_irq)
        else $error("wake interrupt not cleared");

    // a stop write with nothing in its way must be taken
    sequence stop_write_seq;
        s_r.st == admc_pkg::ST_NORMAL && wr_mode && d2d_req.wdata[1:0] == `ADMC_MODE_STOP;
    endsequence
    a_stop_entry: assert property (stop_write_seq ##0 (!s_r.stop_block && s_r.gap_cnt == 2'h0
        && cause_set == 6'h00 && !vto_hit && por_ok) |=> s_r.st == admc_pkg::ST_STOP)
        else $error("stop write not taken");

endmodule : admc_mode_ctrl

// ===== logic/admc_params.svh
// admc_params.svh: offsets, field positions, reset values and timing counts
// of the analog die mode controller.
// assumes a 200 MHz base clock; included by the package and the controller.
`ifndef ADMC_PARAMS_SVH
`define ADMC_PARAMS_SVH

// clock and times, each in its own unit
`define ADMC_CLK_PERIOD_PS 5000
`define ADMC_T_RST_NS      20000
`define ADMC_T_VTO_NS      200000
// reset hold is a least time (round up), timeout a longest time (round down)
`define ADMC_RST_CYCLES ((`ADMC_T_RST_NS * 1000 + `ADMC_CLK_PERIOD_PS - 1) / `ADMC_CLK_PERIOD_PS)
`define ADMC_VTO_CYCLES ((`ADMC_T_VTO_NS * 1000) / `ADMC_CLK_PERIOD_PS)

// register placement in the global address space
`define ADMC_BASE_BLOCKING 16'h0200
`define ADMC_BASE_NONBLOCK 16'h0300
`define ADMC_OFS_MODE      16'h0016
`define ADMC_MODE_RST_VAL  2'h0

// mode field encodings
`define ADMC_MODE_WAKE   2'h0
`define ADMC_MODE_STOP   2'h1
`define ADMC_MODE_SLEEP  2'h2
`define ADMC_MODE_NORMAL 2'h3

// base clock cycles between wake source read and a stop command
`define ADMC_WSR_GAP 2'h2

// reset cause flag positions
`define ADMC_C_POR  0
`define ADMC_C_LVR  1
`define ADMC_C_IO_UNDERVOLTAGE_CAUSE 2
`define ADMC_C_WDR  3
`define ADMC_C_EXR  4
`define ADMC_C_WUR  5

// synchroniser lane positions
`define ADMC_SY_POR  0
`define ADMC_SY_CORE 1
`define ADMC_SY_IO   2
`define ADMC_SY_LVI  3
`define ADMC_SY_PIN  4
`define ADMC_SY_WKIN 5
`define ADMC_SY_LIN  6
`define ADMC_SY_FWU  7

`endif

// ===== logic/admc_pkg.sv
// admc_pkg: types of the analog die mode controller.
// assumes admc_params.svh on the include path.
`include "admc_params.svh"

package admc_pkg;

    // operating modes, one-hot
    typedef enum logic [4:0] {
        ST_PDOWN  = 5'h01,
        ST_RESET  = 5'h02,
        ST_NORMAL = 5'h04,
        ST_STOP   = 5'h08,
        ST_SLEEP  = 5'h10
    } admc_mode_t;

    // register access from the die-to-die interface
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } admc_d2d_req_t;

    // per-function enables by mode
    typedef struct packed {
        logic sensor_supply;
        logic low_side_drivers;
        logic high_side_full;
        logic high_side_cyclic;
        logic adc;
        logic d2d;
        logic wake_inputs_full;
        logic wake_inputs_detect;
        logic low_voltage_port;
        logic lin_full;
        logic lin_wake_detect;
        logic watchdog;
        logic battery_sense;
        logic current_sense;
        logic cyclic_sense;
    } admc_gate_t;

    // whole controller state
    typedef struct packed {
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        admc_mode_t  st;
        logic [1:0]  mode;
        logic [5:0]  cause;
        logic [15:0] hold_cnt;
        logic [23:0] vto_cnt;
        logic        pin_oe;
        logic [1:0]  drv_hist;
        logic        stop_block;
        logic [1:0]  gap_cnt;
        logic        wake_irq;
        logic        wd_windowed;
        logic        reg_on;
        logic        reg_full;
        admc_gate_t  gate;
        logic [7:0]  rdata;
    } admc_state_t;

endpackage : admc_pkg

// ===== bench/admc_mcu_model.sv
// admc_mcu_model: microcontroller die on the far side of the die-to-die link.
// assumes the bench calls its tasks; driven outputs change only at falling edges, reset_pin_in also follows reset_pin_oe.
`timescale 1ns/1ps

module admc_mcu_model (
    input  wire logic                    clock,
    input  wire logic                    reset_pin_oe,
    input  wire logic [7:0]              d2d_rdata,
    output admc_pkg::admc_d2d_req_t      d2d_req,
    output logic                         wake_src_read,
    output logic                         watchdog_service,
    output logic                         reset_pin_in
);
    logic pull_low;

    // open-drain reset line with pull-up, low while either side pulls
    assign reset_pin_in = !(reset_pin_oe || pull_low);

    // idle lines at time zero
    initial begin
        d2d_req = '0;
        wake_src_read = 1'b0;
        watchdog_service = 1'b0;
        pull_low = 1'b0;
    end

    // one-cycle strobe, answer taken the cycle after; released address and data show the inverse, wr and rd drop low
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        d2d_req = {a, w, !w, d};
        @(negedge clock);
        q = d2d_rdata;
        d2d_req = {~a, 1'b0, 1'b0, ~d};
    endtask : access

    // 0 wake source read, 1 watchdog service, else hold the reset line low
    task automatic pulse(input int which, input int n);
        @(negedge clock);
        case (which)
            0: wake_src_read = 1'b1;
            1: watchdog_service = 1'b1;
            default: pull_low = 1'b1;
        endcase
        repeat (n) @(negedge clock);
        {wake_src_read, watchdog_service, pull_low} = 3'b000;
    endtask : pulse
endmodule : admc_mcu_model

// ===== bench/tb_analog_die_mode_controller.sv
// tb_analog_die_mode_controller: self-checking bench of the mode controller.
// assumes admc_pkg compiled first; runs with short reset and timeout counts.
`timescale 1ns/1ps

module tb_analog_die_mode_controller;
    localparam int          RST = 4;
    localparam int          VTO = 20;
    localparam logic [15:0] MA  = 16'h0216;
    localparam logic [15:0] MB  = 16'h0316;
    logic                    clock = 1'b0;
    logic                    arst_n = 1'b0;
    logic [5:0]              cause_clear = 6'h00;
    logic                    wake_cmd = 1'b0;
    logic                    wd_exp = 1'b0;
    logic [3:0]              sup = 4'h0; // main, core, io, above lvi
    logic [2:0]              wk = 3'h0; // wake inputs, lin, forced
    admc_pkg::admc_d2d_req_t d2d_req;
    logic                    src_rd, wd_svc, pin_in, pin_out, pin_oe, regs_on, regs_full, irq, wd_win;
    logic [7:0]              rdata, q;
    logic [5:0]              causes;
    admc_pkg::admc_gate_t    gate;
    admc_pkg::admc_mode_t    op_mode;
    int                      failures = 0;
    int                      n_tests = 0;

    // base clock, 5 ns period
    always #2.5 clock = ~clock;

    admc_mode_ctrl #(.RST_CYCLES(RST), .VTO_CYCLES(VTO)) i_dut (
        .clock(clock), .arst_n(arst_n), .d2d_req(d2d_req), .wake_src_read(src_rd),
        .cause_clear(cause_clear), .d2d_wake_cmd(wake_cmd), .watchdog_expired(wd_exp),
        .watchdog_service(wd_svc), .main_supply_ok(sup[3]), .core_supply_ok(sup[2]),
        .io_supply_ok(sup[1]), .main_above_lvi(sup[0]), .reset_pin_in(pin_in),
        .wake_inputs_event(wk[0]), .lin_wake_event(wk[1]), .forced_wake_event(wk[2]),
        .d2d_rdata(rdata), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .regulators_on(regs_on),
        .regulators_full_current(regs_full), .func_gate(gate), .wake_irq(irq),
        .watchdog_windowed(wd_win), .op_mode(op_mode), .reset_cause_register(causes));

    admc_mcu_model i_mcu (
        .clock(clock), .reset_pin_oe(pin_oe), .d2d_rdata(rdata), .d2d_req(d2d_req),
        .wake_src_read(src_rd), .watchdog_service(wd_svc), .reset_pin_in(pin_in));

    // verdict and end of run
    task automatic conclude;
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // compare of one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for a mode, giving up ends the run
    task automatic wait_mode(input admc_pkg::admc_mode_t m, input int lim);
        int k;
        k = 0;
        while (op_mode !== m && k < lim) begin
            @(negedge clock);
            k++;
        end
        chk({3'h0, op_mode}, {3'h0, m});
        if (op_mode !== m) conclude();
    endtask : wait_mode

    // sensor supply, interface, watchdog, full lin, lin wake, cyclic sense, converter, port
    function automatic logic [7:0] gv();
        return {gate.sensor_supply, gate.d2d, gate.watchdog, gate.lin_full,
                gate.lin_wake_detect, gate.cyclic_sense, gate.adc, gate.low_voltage_port};
    endfunction : gv

    // register helpers and bench-side strobes
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_mcu.access(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        i_mcu.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic ev(input int i);
        @(negedge clock);
        wk[i] = 1'b1;
        repeat (4) @(negedge clock);
        wk = 3'h0;
    endtask : ev
    task automatic clr;
        @(negedge clock);
        cause_clear = 6'h3F;
        @(negedge clock);
        cause_clear = 6'h00;
        @(negedge clock);
        chk({2'h0, causes}, 8'h00);
    endtask : clr
    task automatic stop_cmd;
        i_mcu.pulse(0, 1);
        repeat (2) @(negedge clock);
        wr(MA, 8'h01);
        wait_mode(admc_pkg::ST_STOP, 6);
    endtask : stop_cmd

    // power-up through reset into normal, watchdog start
    task automatic t_power;
        chk({3'h0, op_mode}, 8'h01);
        chk({6'h0, pin_out, pin_oe}, 8'h01);
        sup = 4'hF;
        wait_mode(admc_pkg::ST_RESET, 8);
        wait_mode(admc_pkg::ST_NORMAL, RST + 20);
        chk({2'h0, causes}, 8'h01);
        chk({5'h0, regs_on, regs_full, wd_win}, 8'h06);
        chk(gv(), 8'hF3);
        i_mcu.pulse(1, 1);
        repeat (2) @(negedge clock);
        chk({7'h0, wd_win}, 8'h01);
        clr();
    endtask : t_power

    // mode field decode at both bases, refused address
    task automatic t_mode;
        rd(MA, 8'h00);
        wr(MA, 8'h00);
        repeat (4) @(negedge clock);
        chk({3'h0, op_mode}, 8'h04);
        wr(MA, 8'hFF);
        rd(MA, 8'h03);
        rd(16'h0217, 8'h00);
        wr(MB, 8'h01);
        wait_mode(admc_pkg::ST_STOP, 4);
        chk({6'h0, regs_on, regs_full}, 8'h02);
        chk(gv(), 8'h4C);
        rd(MB, 8'h01);
    endtask : t_mode

    // every stop wake source, interrupt and re-arm by wake source read
    task automatic t_wake;
        @(negedge clock);
        wake_cmd = 1'b1;
        @(negedge clock);
        wake_cmd = 1'b0;
        wait_mode(admc_pkg::ST_NORMAL, 8);
        chk({7'h0, irq}, 8'h01);
        wr(MA, 8'h01);
        repeat (4) @(negedge clock);
        chk({3'h0, op_mode}, 8'h04);
        stop_cmd();
        chk({7'h0, irq}, 8'h00);
        wr(MA, 8'h00);
        wait_mode(admc_pkg::ST_NORMAL, 6);
        for (int i = 0; i < 3; i++) begin
            stop_cmd();
            ev(i);
            wait_mode(admc_pkg::ST_NORMAL, 8);
            chk({7'h0, irq}, 8'h01);
        end
    endtask : t_wake

    // sleep entry, refused interface wake, wake into reset
    task automatic t_sleep;
        i_mcu.pulse(0, 1);
        wr(MA, 8'h02);
        wait_mode(admc_pkg::ST_SLEEP, 4);
        chk({6'h0, regs_on, regs_full}, 8'h00);
        chk(gv(), 8'h0C);
        @(negedge clock);
        wake_cmd = 1'b1;
        @(negedge clock);
        wake_cmd = 1'b0;
        repeat (6) @(negedge clock);
        chk({3'h0, op_mode}, 8'h10);
        ev(1);
        wait_mode(admc_pkg::ST_RESET, 8);
        chk({6'h0, regs_on, pin_oe}, 8'h03);
        chk({2'h0, causes}, 8'h20);
        wait_mode(admc_pkg::ST_NORMAL, RST + 20);
        clr();
    endtask : t_sleep

    // core undervoltage in stop, reset line hold time
    task automatic t_stop_reset;
        int k;
        stop_cmd();
        sup[2] = 1'b0;
        wait_mode(admc_pkg::ST_RESET, 8);
        chk({2'h0, causes}, 8'h02);
        @(negedge clock);
        sup[2] = 1'b1;
        k = 0;
        while (pin_oe === 1'b1 && k < RST + 20) begin
            @(negedge clock);
            k++;
        end
        chk(8'(k), 8'(RST + 2));
        wait_mode(admc_pkg::ST_NORMAL, 8);
        clr();
    endtask : t_stop_reset

    // watchdog and external pin causes, pin low keeps reset
    task automatic t_causes;
        @(negedge clock);
        wd_exp = 1'b1;
        @(negedge clock);
        wd_exp = 1'b0;
        wait_mode(admc_pkg::ST_RESET, 6);
        chk({2'h0, causes}, 8'h08);
        wait_mode(admc_pkg::ST_NORMAL, RST + 20);
        clr();
        fork
            i_mcu.pulse(2, 14);
        join_none
        wait_mode(admc_pkg::ST_RESET, 8);
        repeat (6) @(negedge clock);
        chk({3'h0, op_mode}, 8'h02);
        chk({2'h0, causes}, 8'h10);
        wait_mode(admc_pkg::ST_NORMAL, 30);
        clr();
    endtask : t_causes

    // io undervoltage beyond the timeout, then forced wake
    task automatic t_timeout;
        sup[1] = 1'b0;
        wait_mode(admc_pkg::ST_SLEEP, VTO + 20);
        chk({2'h0, causes}, 8'h04);
        sup[1] = 1'b1;
        ev(2);
        wait_mode(admc_pkg::ST_RESET, 8);
        wait_mode(admc_pkg::ST_NORMAL, RST + 20);
    endtask : t_timeout

    // main sequence
    initial begin
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        t_power();
        t_mode();
        t_wake();
        t_sleep();
        t_stop_reset();
        t_causes();
        t_timeout();
        conclude();
    end
endmodule : tb_analog_die_mode_controller
